// File: hdl/dbsp_pkg.sv
// constants and types shared by the burst sram port logic
package dbsp_pkg;

   // ***********************************************
   // array geometry (x18 organisation)
   // ***********************************************
   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 18;
   localparam int LANE_W   = 9;
   localparam int LANES    = 2;
   localparam int MEM_AW   = ADDR_W + 1;
   localparam int MEM_DEPTH = 1 << MEM_AW;

   // ***********************************************
   // synchronised input bundle layout
   // ***********************************************
   localparam int P_K      = 0;
   localparam int P_KN     = 1;
   localparam int P_C      = 2;
   localparam int P_CN     = 3;
   localparam int P_RPS    = 4;
   localparam int P_WPS    = 5;
   localparam int P_MASK   = 6;
   localparam int P_ADDR   = 8;
   localparam int P_DATA   = P_ADDR + ADDR_W;
   localparam int IN_W     = P_DATA + DATA_W;

   // clocks idle high, selects and masks deasserted
   localparam logic [IN_W-1:0] SYNC_RST = {{(IN_W-8){1'b0}}, 8'hff};

   // ***********************************************
   // reset values and counts
   // ***********************************************
   localparam logic [1:0]        STRAP_WAIT  = 2'h3;
   localparam logic [1:0]        LANE_ALL    = 2'h3;
   localparam logic [1:0]        LANE_NONE   = 2'h0;
   localparam logic [ADDR_W-1:0] ADDR_RST    = 8'h00;
   localparam logic [DATA_W-1:0] DATA_RST    = 18'h00000;
   localparam logic              OFS_FIRST   = 1'b0;
   localparam logic              OFS_SECOND  = 1'b1;

   // read output sequencer
   typedef enum logic [1:0]
   {
      OUT_IDLE = 2'b00,
      OUT_W0   = 2'b01,
      OUT_W1   = 2'b10
   } dbsp_out_t;

endpackage : dbsp_pkg

// File: hdl/dbsp_mem.sv
// two-lane storage array with per-lane write enables and registered read
`timescale 1ns/10ps
module dbsp_mem
   import dbsp_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_clk_en,
   input  wire logic [LANES-1:0]  i_we,
   input  wire logic [MEM_AW-1:0] i_waddr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic [MEM_AW-1:0] i_raddr,
   output logic      [DATA_W-1:0] o_rdata
);

   // ***********************************************
   // one memory per lane
   // ***********************************************
   genvar g;
   generate
      for (g = 0; g < LANES; g++)
      begin : g_lane
         logic [LANE_W-1:0] store [MEM_DEPTH];
         logic [LANE_W-1:0] rd_lane;

         // a masked lane keeps its old contents
         always_ff @(posedge i_clk)
         begin
            if (i_clk_en && i_we[g])
            begin
               store[i_waddr] <= i_wdata[g*LANE_W +: LANE_W];
            end
            if (i_clk_en)
            begin
               rd_lane <= store[i_raddr];
            end
         end

         // each lane owns its own register; the port only gathers them
         assign o_rdata[g*LANE_W +: LANE_W] = rd_lane;
      end
   endgenerate

endmodule : dbsp_mem

// File: hdl/dbsp_port.sv
// read and write port logic of a two-word burst ddr sram
`timescale 1ns/10ps
module dbsp_port
   import dbsp_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_clk_en,
   input  wire logic              i_sys_rst,
   input  wire logic              i_k,
   input  wire logic              i_kn,
   input  wire logic              i_c,
   input  wire logic              i_cn,
   input  wire logic              i_read_port_select_n,
   input  wire logic              i_write_port_select_n,
   input  wire logic [1:0]        i_byte_lane_write_mask_n,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_d,
   output logic      [DATA_W-1:0] o_q,
   output logic                   o_q_oe,
   output logic                   o_single_clock
);

   // ***********************************************
   // state
   // ***********************************************
   typedef struct packed
   {
      logic [IN_W-1:0]   s1;
      logic [IN_W-1:0]   s2;
      logic [IN_W-1:0]   s3;
      logic [1:0]        strap_cnt;
      logic              single;
      logic              wr_pend;
      logic [ADDR_W-1:0] wr_addr;
      logic              rd_pend;
      logic [ADDR_W-1:0] rd_pend_addr;
      logic              rd_armed;
      logic [ADDR_W-1:0] rd_armed_addr;
      dbsp_out_t         ost;
      logic [ADDR_W-1:0] out_addr;
      logic [DATA_W-1:0] q;
      logic              q_oe;
   } dbsp_state_t;

   localparam dbsp_state_t ST_RST = '{
      s1: SYNC_RST, s2: SYNC_RST, s3: SYNC_RST, strap_cnt: 2'h0, single: 1'b0,
      wr_pend: 1'b0, wr_addr: ADDR_RST, rd_pend: 1'b0, rd_pend_addr: ADDR_RST,
      rd_armed: 1'b0, rd_armed_addr: ADDR_RST, ost: OUT_IDLE, out_addr: ADDR_RST,
      q: DATA_RST, q_oe: 1'b0};

   dbsp_state_t       r;
   dbsp_state_t       next_r;
   logic              k_rise;
   logic              kn_rise;
   logic              c_out;
   logic              cn_out;
   logic              wps_n;
   logic              rps_n;
   logic [1:0]        mask_n;
   logic [ADDR_W-1:0] addr;
   logic [LANES-1:0]  mem_we;
   logic [MEM_AW-1:0] mem_waddr;
   logic [MEM_AW-1:0] mem_raddr;
   logic [DATA_W-1:0] mem_rdata;

   // ***********************************************
   // edge detect on the settled stages
   // ***********************************************
   // s1 feeds only s2; edges compare s2 against s3
   assign k_rise  = r.s2[P_K]  & ~r.s3[P_K];
   assign kn_rise = r.s2[P_KN] & ~r.s3[P_KN];
   // in single clock mode the input clocks time the outputs
   assign c_out   = r.single ? k_rise  : (r.s2[P_C]  & ~r.s3[P_C]);
   assign cn_out  = r.single ? kn_rise : (r.s2[P_CN] & ~r.s3[P_CN]);
   // controls taken one stage behind the edge, for setup margin
   assign wps_n   = r.s3[P_WPS];
   assign rps_n   = r.s3[P_RPS];
   assign mask_n  = r.s3[P_MASK +: 2];
   assign addr    = r.s3[P_ADDR +: ADDR_W];

   // ***********************************************
   // next state
   // ***********************************************
   always_comb
   begin
      next_r    = r;
      mem_we    = LANE_NONE;
      mem_waddr = {addr, OFS_FIRST};
      next_r.s1 = {i_d, i_addr, i_byte_lane_write_mask_n, i_write_port_select_n,
                   i_read_port_select_n, i_cn, i_c, i_kn, i_k};
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;

      // strap sampled once the synchronisers hold real pin levels
      if (r.strap_cnt != STRAP_WAIT)
      begin
         next_r.strap_cnt = r.strap_cnt + 2'h1;
         if (r.strap_cnt == STRAP_WAIT - 2'h1)
         begin
            next_r.single = r.s2[P_C] & r.s2[P_CN];
         end
      end

      // write port; each word gets its own mask sample
      if (k_rise && !wps_n)
      begin
         mem_we         = ~mask_n;
         mem_waddr      = {addr, OFS_FIRST};
         next_r.wr_pend = 1'b1;
         next_r.wr_addr = addr;
      end
      else if (kn_rise && r.wr_pend)
      begin
         mem_we         = ~mask_n;
         mem_waddr      = {r.wr_addr, OFS_SECOND};
         next_r.wr_pend = 1'b0;
      end

      // read port: latch at t, arm at t+1
      if (k_rise)
      begin
         next_r.rd_armed      = r.rd_pend;
         next_r.rd_armed_addr = r.rd_pend_addr;
         next_r.rd_pend       = !rps_n;
         next_r.rd_pend_addr  = addr;
      end

      if (cn_out)
      begin
         if (r.rd_armed)
         begin
            next_r.q        = mem_rdata;
            next_r.q_oe     = 1'b1;
            next_r.ost      = OUT_W0;
            next_r.out_addr = r.rd_armed_addr;
            if (!k_rise)
            begin
               next_r.rd_armed = 1'b0;
            end
         end
         else if (r.ost == OUT_W1)
         begin
            next_r.q_oe = 1'b0;
            next_r.ost  = OUT_IDLE;
         end
      end
      else if (c_out && r.ost == OUT_W0)
      begin
         next_r.q   = mem_rdata;
         next_r.ost = OUT_W1;
      end
   end

   // word two is fetched once word one is out; writes land before any
   // output edge, so a read always sees the newest data
   assign mem_raddr = (r.ost == OUT_W0) ? {r.out_addr, OFS_SECOND}
                                        : {r.rd_armed_addr, OFS_FIRST};

   // a stopped clock simply yields no edges, so all state is held
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         r <= ST_RST;
      end
      else if (i_clk_en)
      begin
         r <= next_r;
      end
   end

   dbsp_mem u_mem
   (
      .i_clk    (i_clk),
      .i_clk_en (i_clk_en),
      .i_we     (mem_we),
      .i_waddr  (mem_waddr),
      .i_wdata  (r.s3[P_DATA +: DATA_W]),
      .i_raddr  (mem_raddr),
      .o_rdata  (mem_rdata)
   );

   assign o_q            = r.q;
   assign o_q_oe         = r.q_oe;
   assign o_single_clock = r.single;

   // ***********************************************
   // checks
   // ***********************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   a_wr_first_word: assert property (
      k_rise && !wps_n |-> mem_waddr == {addr, OFS_FIRST} && mem_we == ~mask_n)
      else $error("first write word wrong");
   a_wr_second_word: assert property (
      kn_rise && !k_rise && r.wr_pend |-> mem_waddr == {r.wr_addr, OFS_SECOND})
      else $error("second write word wrong");
   a_lane_full_word: assert property (
      (k_rise && !wps_n || kn_rise && r.wr_pend) && mask_n == 2'h0 |-> mem_we == 2'h3)
      else $error("full word not written");
   a_lane_low_only: assert property (
      (k_rise && !wps_n || kn_rise && r.wr_pend) && mask_n == 2'h2 |-> mem_we == 2'h1)
      else $error("low lane only failed");
   a_lane_up_only: assert property (
      (k_rise && !wps_n || kn_rise && r.wr_pend) && mask_n == 2'h1 |-> mem_we == 2'h2)
      else $error("upper lane only failed");
   a_lane_none: assert property (
      mask_n == 2'h3 |-> mem_we == 2'h0)
      else $error("masked word written");
   a_wr_pend_set: assert property (
      k_rise && !wps_n && i_clk_en |=> r.wr_pend && r.wr_addr == $past(addr))
      else $error("write burst not held");
   a_read_arm: assert property (
      k_rise && r.rd_pend && i_clk_en |=> r.rd_armed)
      else $error("read not armed");
   a_first_out: assert property (
      cn_out && r.rd_armed && i_clk_en |=> o_q_oe && o_q == $past(mem_rdata) && r.ost == OUT_W0)
      else $error("first read word missing");
   a_second_out: assert property (
      c_out && !cn_out && r.ost == OUT_W0 && i_clk_en |=> o_q == $past(mem_rdata)
         && r.ost == OUT_W1)
      else $error("second read word missing");
   a_fetch_addr: assert property (
      r.ost == OUT_W0 |-> mem_raddr == {r.out_addr, OFS_SECOND})
      else $error("read offset wrong");
   a_tail_hiz: assert property (
      cn_out && !r.rd_armed && r.ost == OUT_W1 && i_clk_en |=> !o_q_oe && r.ost == OUT_IDLE)
      else $error("outputs not released");
   a_idle_quiet: assert property (
      r.ost == OUT_IDLE |-> !o_q_oe)
      else $error("outputs driven while idle");

endmodule : dbsp_port

// File: sim/dbsp_host.sv
// host controller model driving the burst sram link pins
`timescale 1ns/10ps
module dbsp_host
   import dbsp_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic [DATA_W-1:0] i_q,
   input  wire logic              i_q_oe,
   output logic                   o_k,
   output logic                   o_kn,
   output logic                   o_c,
   output logic                   o_cn,
   output logic                   o_rps_n,
   output logic                   o_wps_n,
   output logic [1:0]             o_mask_n,
   output logic [ADDR_W-1:0]      o_addr,
   output logic [DATA_W-1:0]      o_d
);
   // set once the output clocks are strapped high; they then never toggle
   logic oc_hold = 1'b0;

   // output clocks low at power-on keep the two-clock mode
   initial
   begin
      {o_k, o_kn, o_c, o_cn} = 4'hc;
      {o_rps_n, o_wps_n, o_mask_n} = 4'hf;
      o_addr = ADDR_RST;
      o_d    = DATA_RST;
   end

   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
   endtask : step

   // parked high for the quickest restart
   task automatic park();
      {o_k, o_kn, o_c, o_cn} <= 4'hf;
      step(8);
   endtask : park

   task automatic start();
      {o_k, o_kn} <= 2'h1;
      if (!oc_hold)
      begin
         {o_c, o_cn} <= 2'h1;
      end
      step(8);
   endtask : start

   // output clocks held high from here on select single clock mode
   task automatic hold_out_clocks();
      oc_hold = 1'b1;
      park();
   endtask : hold_out_clocks

   // one k period; q sampled after the c rise and after the cn rise
   task automatic kcycle(input logic rd_n, input logic wr_n, input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1, input logic [1:0] m0,
         input logic [1:0] m1, output logic [DATA_W-1:0] q_c,
         output logic [DATA_W-1:0] q_cn, output logic oe_c, output logic oe_cn);
      {o_rps_n, o_wps_n, o_addr, o_d, o_mask_n} <= {rd_n, wr_n, a, d0, m0};
      step(4);
      {o_k, o_kn} <= 2'h2;
      if (!oc_hold)
      begin
         {o_c, o_cn} <= 2'h2;
      end
      step(4);
      // released selects go high and the address shows its inverse, never the old value
      {o_rps_n, o_wps_n, o_addr, o_d, o_mask_n} <= {2'h3, ~a, d1, m1};
      step(3);
      #1 {q_c, oe_c} = {i_q, i_q_oe};
      step(1);
      {o_k, o_kn} <= 2'h1;
      if (!oc_hold)
      begin
         {o_c, o_cn} <= 2'h1;
      end
      step(4);
      o_d <= ~d1;
      step(3);
      #1 {q_cn, oe_cn} = {i_q, i_q_oe};
      step(1);
   endtask : kcycle
endmodule : dbsp_host

// File: sim/tb_top.sv
// self-checking bench for the burst sram port logic
`timescale 1ns/10ps
module tb_top
   import dbsp_pkg::*;
   ;
   localparam logic [DATA_W-1:0] JUNK = 18'h3ffff;
   logic              i_clk = 1'b0;
   logic              i_sys_rst = 1'b1;
   logic              clk_en = 1'b1;
   logic              k, kn, c, cn, rps_n, wps_n, q_oe, single_clk, oec, oecn;
   logic [1:0]        mask_n;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] d, q, qc, qcn;
   logic [DATA_W-1:0] exp_mem [MEM_DEPTH];
   int                error_cnt = 0;
   int                n_checks = 0;

   always #5 i_clk = ~i_clk;

   dbsp_port DUT (.i_clk(i_clk), .i_clk_en(clk_en), .i_sys_rst(i_sys_rst), .i_k(k),
      .i_kn(kn), .i_c(c), .i_cn(cn), .i_read_port_select_n(rps_n),
      .i_write_port_select_n(wps_n), .i_byte_lane_write_mask_n(mask_n), .i_addr(addr),
      .i_d(d), .o_q(q), .o_q_oe(q_oe), .o_single_clock(single_clk));
   dbsp_host host (.i_clk(i_clk), .i_q(q), .i_q_oe(q_oe), .o_k(k), .o_kn(kn), .o_c(c),
      .o_cn(cn), .o_rps_n(rps_n), .o_wps_n(wps_n), .o_mask_n(mask_n), .o_addr(addr),
      .o_d(d));

   // ***********************************************
   // helpers
   // ***********************************************
   task automatic cmp_d(input string what, input logic [DATA_W-1:0] e,
         input logic [DATA_W-1:0] g);
      n_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask : cmp_d

   task automatic cmp_b(input string what, input logic e, input logic g);
      cmp_d(what, {17'h0, e}, {17'h0, g});
   endtask : cmp_b

   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
         input logic [DATA_W-1:0] n, input logic [1:0] m);
      merge = o;
      if (!m[0]) merge[LANE_W-1:0] = n[LANE_W-1:0];
      if (!m[1]) merge[DATA_W-1:LANE_W] = n[DATA_W-1:LANE_W];
   endfunction : merge

   task automatic op(input logic rd_n, input logic wr_n, input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1, input logic [1:0] m0,
         input logic [1:0] m1);
      if (!wr_n)
      begin
         exp_mem[{a, OFS_FIRST}]  = merge(exp_mem[{a, OFS_FIRST}], d0, m0);
         exp_mem[{a, OFS_SECOND}] = merge(exp_mem[{a, OFS_SECOND}], d1, m1);
      end
      host.kcycle(rd_n, wr_n, a, d0, d1, m0, m1, qc, qcn, oec, oecn);
   endtask : op

   // two deselected cycles with live data on the pins
   task automatic chk_rd(input logic [ADDR_W-1:0] a);
      op(1'b1, 1'b1, a, JUNK, JUNK, 2'h0, 2'h0);
      cmp_d("first word", exp_mem[{a, OFS_FIRST}], qcn);
      cmp_b("oe first", 1'b1, oecn);
      op(1'b1, 1'b1, a, JUNK, JUNK, 2'h0, 2'h0);
      cmp_d("second word", exp_mem[{a, OFS_SECOND}], qc);
      cmp_b("oe second", 1'b1, oec);
      cmp_b("oe release", 1'b0, oecn);
   endtask : chk_rd

   // ***********************************************
   // scenarios
   // ***********************************************
   task automatic t_reset();
      cmp_b("oe idle", 1'b0, q_oe);
      cmp_b("single mode", 1'b0, single_clk);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_full();
      op(1'b1, 1'b0, 8'h5a, 18'h1b3c5, 18'h2d4e6, 2'h0, 2'h0);
      op(1'b0, 1'b1, 8'h5a, JUNK, JUNK, 2'h0, 2'h0);
      chk_rd(8'h5a);
      $display("t_full done");
   endtask : t_full

   task automatic t_lanes();
      op(1'b1, 1'b0, 8'h33, 18'h12345, 18'h0fedc, 2'h0, 2'h0);
      op(1'b1, 1'b0, 8'h33, JUNK, JUNK, 2'h2, 2'h1);
      op(1'b1, 1'b0, 8'h33, 18'h0, 18'h0, 2'h3, 2'h3);
      op(1'b0, 1'b1, 8'h33, JUNK, JUNK, 2'h0, 2'h0);
      chk_rd(8'h33);
      $display("t_lanes done");
   endtask : t_lanes

   task automatic t_same();
      op(1'b0, 1'b0, 8'h77, 18'h0a0a0, 18'h05050, 2'h0, 2'h0);
      chk_rd(8'h77);
      $display("t_same done");
   endtask : t_same

   // back to back reads leave no high-z gap
   task automatic t_b2b();
      op(1'b0, 1'b1, 8'h5a, JUNK, JUNK, 2'h0, 2'h0);
      op(1'b0, 1'b1, 8'h33, JUNK, JUNK, 2'h0, 2'h0);
      cmp_d("b2b a0", exp_mem[{8'h5a, OFS_FIRST}], qcn);
      op(1'b1, 1'b1, 8'h00, JUNK, JUNK, 2'h0, 2'h0);
      cmp_d("b2b a1", exp_mem[{8'h5a, OFS_SECOND}], qc);
      cmp_d("b2b b0", exp_mem[{8'h33, OFS_FIRST}], qcn);
      cmp_b("b2b oe", 1'b1, oecn);
      op(1'b1, 1'b1, 8'h00, JUNK, JUNK, 2'h0, 2'h0);
      cmp_d("b2b b1", exp_mem[{8'h33, OFS_SECOND}], qc);
      cmp_b("b2b end", 1'b0, oecn);
      $display("t_b2b done");
   endtask : t_b2b

   task automatic t_park();
      host.park();
      clk_en <= 1'b0;
      repeat (10) @(posedge i_clk);
      clk_en <= 1'b1;
      host.start();
      cmp_b("oe parked", 1'b0, q_oe);
      op(1'b0, 1'b1, 8'h77, JUNK, JUNK, 2'h0, 2'h0);
      chk_rd(8'h77);
      $display("t_park done");
   endtask : t_park

   // second reset with the output clocks high straps single clock mode;
   // reads then only come out if the input clocks time the outputs
   task automatic t_single();
      host.hold_out_clocks();
      i_sys_rst <= 1'b1;
      repeat (3) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      repeat (6) @(posedge i_clk);
      cmp_b("single strap", 1'b1, single_clk);
      cmp_b("oe after reset", 1'b0, q_oe);
      host.start();
      op(1'b1, 1'b0, 8'h21, 18'h2a5c3, 18'h1e7b4, 2'h0, 2'h0);
      op(1'b0, 1'b1, 8'h21, JUNK, JUNK, 2'h0, 2'h0);
      chk_rd(8'h21);
      $display("t_single done");
   endtask : t_single

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run

   initial
   begin
      repeat (3) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      repeat (6) @(posedge i_clk);
      t_reset();
      host.start();
      t_full();
      t_lanes();
      t_same();
      t_b2b();
      t_park();
      t_single();
      complete_run();
   end

   // about 550 cycles of traffic expected
   initial
   begin
      repeat (4000) @(posedge i_clk);
      error_cnt++;
      complete_run();
   end
endmodule : tb_top
